// file: rtl/sal_pkg.sv
// Package of types and constants for the scaled add and word load datapath.
package sal_pkg;

    localparam int XLEN = 64;

    // Minor codes of the two scaled add forms.
    localparam logic [5:0] MINOR_SCALED_WORD  = 6'h0F;
    localparam logic [5:0] MINOR_SCALED_DWORD = 6'h04;

    // Major pools that carry the scaled adds.
    localparam logic [5:0] POOL_A_MAJOR = 6'h00;
    localparam logic [5:0] POOL_S_MAJOR = 6'h16;

    // Field positions within a lane of the fetched doubleword.
    localparam int WORD_SIGN_BIT   = 31;
    localparam int UPPER_IMM_SHIFT = 16;
    localparam int LOW_ADDR_BITS   = 2;

    // Offset widths of the load forms.
    localparam int OFFSET_WIDE     = 16;
    localparam int OFFSET_COP2_R6  = 11;
    localparam int OFFSET_USER     = 9;

    // Reset value of the result and request registers.
    localparam logic [63:0] RESULT_RESET = 64'h0000_0000_0000_0000;

    // Operation selected by the decode stage.
    typedef enum logic [3:0] {
        SAL_OP_NONE,
        SAL_OP_SCALED_WORD,
        SAL_OP_SCALED_DWORD,
        SAL_OP_UPPER_IMM,
        SAL_OP_LOAD_GENERAL,
        SAL_OP_LOAD_FLOAT,
        SAL_OP_LOAD_COP2,
        SAL_OP_LOAD_USER
    } sal_op_t;

    // Access mode of the segment holding an address.
    typedef enum logic [2:0] {
        SAL_SEG_UNMAPPED_USER,
        SAL_SEG_MAPPED_USER,
        SAL_SEG_MAPPED_USER_FROM_KERNEL,
        SAL_SEG_OTHER
    } sal_seg_t;

    // Destination register file of a result.
    typedef enum logic [1:0] {
        SAL_DST_GENERAL,
        SAL_DST_FLOAT,
        SAL_DST_COP2
    } sal_dst_t;

    // Instruction issued by decode.
    typedef struct packed {
        sal_op_t     op;
        logic [5:0]  major;
        logic [5:0]  minor;
        logic [1:0]  shift_amount_field;
        logic [63:0] scaled_source_register;
        logic [63:0] target_register;
        logic [63:0] base;
        logic [15:0] offset;
        logic [4:0]  dest;
    } sal_issue_t;

    // Exception flags reported with a result.
    typedef struct packed {
        logic tlb_refill;
        logic tlb_invalid;
        logic bus_error;
        logic address_error;
        logic watch;
        logic reserved_instr;
        logic cop_unusable;
    } sal_exc_t;

    // Answer of the translation and memory subsystem.
    typedef struct packed {
        logic [63:0] doubleword;
        logic        tlb_refill;
        logic        tlb_invalid;
        logic        bus_error;
        logic        watch;
    } sal_mem_t;

    // Result written back.
    typedef struct packed {
        sal_dst_t    dst;
        logic [4:0]  dest;
        logic [63:0] value;
        sal_exc_t    exc;
    } sal_result_t;

endpackage : sal_pkg

// file: rtl/sal_scaled_add.sv
// Combinational scaled index adder for word and doubleword forms.
module sal_scaled_add
    import sal_pkg::*;
(
    input  wire logic [63:0] src_shifted,
    input  wire logic [63:0] src_added,
    input  wire logic [1:0]  shift_amount_field,
    input  wire logic        doubleword,
    output logic      [63:0] sum
);

    logic [2:0]  shift_count;
    logic [63:0] full_sum;

    // Shift count is the field plus one, so scales of 2 to 16.
    assign shift_count = {1'b0, shift_amount_field} + 3'h1; // RULE_02 RULE_20
    assign full_sum = (src_shifted << shift_count) + src_added; // RULE_03

    // Word form folds the low 32 bits back to a signed value.
    assign sum = doubleword ? full_sum
               : {{32{full_sum[WORD_SIGN_BIT]}}, full_sum[31:0]}; // RULE_01

endmodule : sal_scaled_add

// file: rtl/sal_lane_select.sv
// Picks the addressed word lane out of a fetched doubleword.
module sal_lane_select
    import sal_pkg::*;
(
    input  wire logic [63:0] doubleword,
    input  wire logic [2:0]  vaddr_low,
    input  wire logic        big_endian_flag,
    output logic      [31:0] word
);

    logic [2:0] byte_sel;

    // Big endian flips which half of the doubleword holds the word.
    assign byte_sel = vaddr_low ^ {big_endian_flag, 2'b00}; // RULE_11
    assign word = byte_sel[2] ? doubleword[63:32] : doubleword[31:0];

endmodule : sal_lane_select

// file: rtl/sal_datapath.sv
// Execution stage for scaled adds, upper immediate and word loads.
// What this block does
// RULE_01: Word scaled add sign-extends bit 31 upward.
// RULE_02: Shift count is unsigned field plus one.
// RULE_03: Doubleword scaled add is full 64-bit.
// RULE_04: Decode scaled adds by pool and minor.
// RULE_05: Upper immediate to bits 31..16, sign-extended.
// RULE_06: Upper immediate is add-upper with zero source.
// RULE_07: Load address is base plus signed offset.
// RULE_08: General and user loads sign-extend word.
// RULE_09: Pre-R6 misaligned word load gives address error.
// RULE_10: R6 may allow misaligned word loads.
// RULE_11: Lane select by XOR with big endian flag; reverse flag goes to memory.
// RULE_12: Float load fills low half only.
// RULE_13: Cop2 load low word, 11-bit R6 offset.
// RULE_14: User load uses 9-bit signed offset.
// RULE_15: User load allowed in three segment types.
// RULE_16: User load needs enhanced addressing, cop0.
// RULE_17: User load faults: RI, CpU, AdE.
// RULE_18: Loads raise memory exceptions (no bus error on float, cop2); adds raise none.
// RULE_19: Float loads add CpU; cop2 loads add RI, CpU.
// RULE_20: Scale factors are two through sixteen.
module sal_datapath
    import sal_pkg::*;
#(
    parameter bit MISALIGN_SUPPORT = 1'b0
)
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        issue_valid,
    input  wire sal_issue_t  issue,
    input  wire logic        release6_mode,
    input  wire logic        enhanced_addressing_enable_bit,
    input  wire logic        cop0_enabled,
    input  wire logic        cop1_enabled,
    input  wire logic        cop2_enabled,
    input  wire logic        cop2_present,
    input  wire logic        big_endian_flag,
    input  wire logic        reverse_endian_flag,
    input  wire sal_seg_t    segment_mode,
    input  wire logic        mem_valid,
    input  wire sal_mem_t    mem_resp,
    output logic             busy_q,
    output logic             mem_req_q,
    output logic      [63:0] mem_vaddr_q,
    output logic             mem_user_map_q,
    output logic             mem_reverse_q,
    output logic             result_valid_q,
    output sal_result_t      result_q
);

    ////////////////////////////////////////////////////////////////////////
    // Decode and address arithmetic.

    typedef enum logic [1:0] {
        SAL_ST_IDLE,
        SAL_ST_WAIT
    } sal_state_t;

    sal_state_t  state_q;
    sal_op_t     op;
    logic        is_load;
    logic        scaled_dword;
    logic [63:0] scaled_sum;
    logic [63:0] offset_ext;
    logic [63:0] eff_addr;
    logic [63:0] upper_imm;
    sal_exc_t    early_exc;
    logic        early_fault;
    logic [31:0] lane_word;
    logic [2:0]  held_vlow_q;
    logic        held_big_q;
    sal_op_t     held_op_q;
    logic [4:0]  held_dest_q;

    // Sign-extend the low bits of an offset field of a given width.
    function automatic logic [63:0] sext_offset(input logic [15:0] raw,
                                                input int          width);
        logic [63:0] v;
        v = 64'h0;
        for (int i = 0; i < 64; i++) begin
            v[i] = (i < width) ? raw[i] : raw[width - 1];
        end
        return v;
    endfunction : sext_offset

    // Sign-extend a 32-bit word to register width.
    function automatic logic [63:0] sext_word(input logic [31:0] w);
        return {{32{w[WORD_SIGN_BIT]}}, w};
    endfunction : sext_word

    // Scaled adds are recognised by pool and minor, which override decode's tag.
    always_comb begin
        op = issue.op;
        if (issue.major == POOL_A_MAJOR
            && issue.minor == MINOR_SCALED_WORD) begin
            op = SAL_OP_SCALED_WORD; // RULE_04
        end else if (issue.major == POOL_S_MAJOR
                     && issue.minor == MINOR_SCALED_DWORD) begin
            op = SAL_OP_SCALED_DWORD; // RULE_04
        end
    end

    assign is_load = (op == SAL_OP_LOAD_GENERAL) || (op == SAL_OP_LOAD_FLOAT)
                  || (op == SAL_OP_LOAD_COP2) || (op == SAL_OP_LOAD_USER);
    assign scaled_dword = (op == SAL_OP_SCALED_DWORD);

    sal_scaled_add u_scaled_add (
        .src_shifted        (issue.scaled_source_register),
        .src_added          (issue.target_register),
        .shift_amount_field (issue.shift_amount_field),
        .doubleword         (scaled_dword),
        .sum                (scaled_sum)
    );

    // Offset width depends on the load form and the release mode.
    always_comb begin
        unique case (op)
            SAL_OP_LOAD_USER: offset_ext = sext_offset(issue.offset,
                                                       OFFSET_USER); // RULE_14
            SAL_OP_LOAD_COP2: offset_ext = release6_mode
                ? sext_offset(issue.offset, OFFSET_COP2_R6)
                : sext_offset(issue.offset, OFFSET_WIDE); // RULE_13
            default:          offset_ext = sext_offset(issue.offset,
                                                       OFFSET_WIDE); // RULE_07
        endcase
    end
    assign eff_addr = issue.base + offset_ext; // RULE_07

    // Upper immediate is the add-upper form with a zero source register,
    // so a constant zero is added to the shifted immediate here, apart from the scaled adder.
    assign upper_imm = 64'h0 + sext_word({issue.offset,
                       {UPPER_IMM_SHIFT{1'b0}}}); // RULE_05 RULE_06

    // Faults that are known before any memory access is made.
    always_comb begin
        early_exc = '0;
        if (is_load && !(release6_mode && MISALIGN_SUPPORT)
            && eff_addr[LOW_ADDR_BITS-1:0] != 2'b00) begin
            early_exc.address_error = 1'b1; // RULE_09 RULE_10
        end
        if (op == SAL_OP_LOAD_FLOAT && !cop1_enabled) begin
            early_exc.cop_unusable = 1'b1; // RULE_19
        end
        if (op == SAL_OP_LOAD_COP2) begin
            early_exc.reserved_instr = !cop2_present; // RULE_19
            early_exc.cop_unusable = cop2_present && !cop2_enabled; // RULE_19
        end
        // User-space loads check in order: availability, cop0, segment.
        if (op == SAL_OP_LOAD_USER) begin
            if (!enhanced_addressing_enable_bit) begin
                early_exc = '0;
                early_exc.reserved_instr = 1'b1; // RULE_16 RULE_17
            end else if (!cop0_enabled) begin
                early_exc = '0;
                early_exc.cop_unusable = 1'b1; // RULE_16 RULE_17
            end else if (segment_mode == SAL_SEG_OTHER) begin
                early_exc.address_error = 1'b1; // RULE_15 RULE_17
            end
        end
    end
    assign early_fault = |early_exc;

    ////////////////////////////////////////////////////////////////////////
    // Sequencing of a load through the memory subsystem.

    // One load at a time; decode holds off while busy is high.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= SAL_ST_IDLE;
        end else begin
            unique case (state_q)
                SAL_ST_IDLE: begin
                    if (issue_valid && is_load && !early_fault) begin
                        state_q <= SAL_ST_WAIT;
                    end
                end
                SAL_ST_WAIT: begin
                    if (mem_valid) begin
                        state_q <= SAL_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Request to translation; user loads from a mapped-user-from-kernel segment ask for the user mapping.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mem_req_q      <= 1'b0;
            mem_vaddr_q    <= RESULT_RESET;
            mem_user_map_q <= 1'b0;
            mem_reverse_q  <= 1'b0;
            busy_q         <= 1'b0;
        end else if (state_q == SAL_ST_IDLE) begin
            mem_req_q <= issue_valid && is_load && !early_fault;
            busy_q    <= issue_valid && is_load && !early_fault;
            if (issue_valid && is_load) begin
                mem_vaddr_q    <= eff_addr;
                mem_user_map_q <= (op == SAL_OP_LOAD_USER)
                    && (segment_mode == SAL_SEG_MAPPED_USER_FROM_KERNEL);
                mem_reverse_q  <= reverse_endian_flag; // RULE_11
            end
        end else begin
            mem_req_q <= 1'b0;
            busy_q    <= !mem_valid;
        end
    end

    // Facts about the pending load kept for the answer.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            held_vlow_q <= 3'h0;
            held_big_q  <= 1'b0;
            held_op_q   <= SAL_OP_NONE;
            held_dest_q <= 5'h00;
        end else if (state_q == SAL_ST_IDLE && issue_valid) begin
            held_vlow_q <= eff_addr[2:0];
            held_big_q  <= big_endian_flag;
            held_op_q   <= op;
            held_dest_q <= issue.dest;
        end
    end

    sal_lane_select u_lane_select (
        .doubleword      (mem_resp.doubleword),
        .vaddr_low       (held_vlow_q),
        .big_endian_flag (held_big_q),
        .word            (lane_word)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write-back of results and exceptions.

    // Adds and faulted loads finish in one cycle; other loads finish when memory answers.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            result_valid_q <= 1'b0;
            result_q       <= '0;
        end else begin
            result_valid_q <= 1'b0;
            if (state_q == SAL_ST_IDLE && issue_valid) begin
                result_q.dest <= issue.dest;
                result_q.dst  <= SAL_DST_GENERAL;
                result_q.exc  <= '0; // RULE_18
                unique case (op)
                    SAL_OP_SCALED_WORD, SAL_OP_SCALED_DWORD: begin
                        result_valid_q <= 1'b1;
                        result_q.value <= scaled_sum;
                    end
                    SAL_OP_UPPER_IMM: begin
                        result_valid_q <= 1'b1;
                        result_q.value <= upper_imm;
                    end
                    default: begin
                        // Faulted loads answer at once with no data.
                        result_valid_q <= is_load && early_fault;
                        result_q.value <= RESULT_RESET;
                        result_q.exc   <= early_exc;
                    end
                endcase
            end else if (state_q == SAL_ST_WAIT && mem_valid) begin
                result_valid_q           <= 1'b1;
                result_q.dest            <= held_dest_q;
                result_q.exc             <= '0;
                result_q.exc.tlb_refill  <= mem_resp.tlb_refill; // RULE_18
                result_q.exc.tlb_invalid <= mem_resp.tlb_invalid;
                result_q.exc.bus_error   <= mem_resp.bus_error
                                            && held_op_q != SAL_OP_LOAD_FLOAT
                                            && held_op_q != SAL_OP_LOAD_COP2;
                result_q.exc.watch       <= mem_resp.watch;
                unique case (held_op_q)
                    SAL_OP_LOAD_FLOAT: begin
                        // Upper half left zero; software sees it as undefined.
                        result_q.dst   <= SAL_DST_FLOAT;
                        result_q.value <= {32'h0, lane_word}; // RULE_12
                    end
                    SAL_OP_LOAD_COP2: begin
                        result_q.dst   <= SAL_DST_COP2;
                        result_q.value <= {32'h0, lane_word}; // RULE_13
                    end
                    default: begin
                        result_q.dst   <= SAL_DST_GENERAL;
                        result_q.value <= sext_word(lane_word); // RULE_08
                    end
                endcase
            end
        end
    end

endmodule : sal_datapath

// file: verification/sal_datapath_monitor.sv
// Concurrent checks on the datapath ports, bound into the design.
module sal_datapath_monitor
    import sal_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        issue_valid,
    input wire sal_issue_t  issue,
    input wire logic        release6_mode,
    input wire logic        enhanced_addressing_enable_bit,
    input wire logic        mem_valid,
    input wire logic        busy_q,
    input wire logic        mem_req_q,
    input wire logic [63:0] mem_vaddr_q,
    input wire logic        result_valid_q,
    input wire sal_result_t result_q
);
    timeunit 1ns;
    timeprecision 1ps;

    logic        take;
    logic        is_w;
    logic        is_d;
    logic        plain;
    logic [63:0] sum;
    logic [63:0] ea;

    // Scaled add codes override op, so plain ops exclude both of them.
    always_comb begin
        take  = issue_valid && !busy_q;
        is_w  = issue.major == POOL_A_MAJOR
            && issue.minor == MINOR_SCALED_WORD;
        is_d  = issue.major == POOL_S_MAJOR
            && issue.minor == MINOR_SCALED_DWORD;
        plain = take && !is_w && !is_d;
        sum   = (issue.scaled_source_register
            << (issue.shift_amount_field + 3'd1)) + issue.target_register;
        ea    = issue.base + {{48{issue.offset[15]}}, issue.offset};
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    property p_word;
        take && is_w |=> result_valid_q && result_q.exc == '0
            && result_q.value == {{32{$past(sum[31])}}, $past(sum[31:0])};
    endproperty
    a_word: assert property (p_word)
        else $error("word scaled add result wrong");
    property p_dword;
        take && is_d |=> result_valid_q && result_q.value == $past(sum);
    endproperty
    a_dword: assert property (p_dword)
        else $error("doubleword scaled add result wrong");
    property p_upper;
        plain && issue.op == SAL_OP_UPPER_IMM |=> result_valid_q
            && result_q.value == {{32{$past(issue.offset[15])}},
                $past(issue.offset), 16'h0000};
    endproperty
    a_upper: assert property (p_upper)
        else $error("upper immediate result wrong");
    property p_addr;
        plain && issue.op == SAL_OP_LOAD_GENERAL && !release6_mode
            && ea[1:0] == 2'b00 |=> mem_req_q && busy_q
            && mem_vaddr_q == $past(ea);
    endproperty
    a_addr: assert property (p_addr)
        else $error("load address wrong");
    property p_align;
        plain && issue.op == SAL_OP_LOAD_GENERAL && !release6_mode
            && ea[1:0] != 2'b00 |=> result_valid_q && !mem_req_q
            && result_q.exc.address_error;
    endproperty
    a_align: assert property (p_align)
        else $error("misaligned load not faulted");
    property p_user_ri;
        plain && issue.op == SAL_OP_LOAD_USER
            && !enhanced_addressing_enable_bit
            |=> result_valid_q && !mem_req_q && result_q.exc.reserved_instr;
    endproperty
    a_user_ri: assert property (p_user_ri)
        else $error("user load without enhanced addressing not refused");
    property p_req_pulse;
        mem_req_q |=> !mem_req_q && busy_q;
    endproperty
    a_req_pulse: assert property (p_req_pulse)
        else $error("request pulse longer than one cycle");
    property p_answer;
        busy_q && mem_valid |=> result_valid_q && !busy_q;
    endproperty
    a_answer: assert property (p_answer)
        else $error("memory answer not forwarded");
endmodule : sal_datapath_monitor

bind sal_datapath sal_datapath_monitor u_mon (
    .core_clk, .sys_rst, .issue_valid, .issue, .release6_mode,
    .enhanced_addressing_enable_bit, .mem_valid, .busy_q, .mem_req_q,
    .mem_vaddr_q, .result_valid_q, .result_q
);

// file: verification/sal_mem_model.sv
// Memory and translation responder that answers each request late.
module sal_mem_model
    import sal_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        mem_req_q,
    input wire logic [3:0]  lat,
    input wire logic [63:0] data,
    input wire logic [3:0]  errs,
    output logic            mem_valid,
    output sal_mem_t        mem_resp
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       pend_q;
    logic [3:0] cnt_q;

    // Wait lat cycles; the answer never lands in the request's own cycle.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pend_q    <= 1'b0;
            cnt_q     <= 4'h0;
            mem_valid <= 1'b0;
        end else begin
            mem_valid <= 1'b0;
            if (mem_req_q) begin
                pend_q <= 1'b1;
                cnt_q  <= lat;
            end else if (pend_q) begin
                cnt_q <= cnt_q - 4'h1;
                if (cnt_q <= 4'h1) begin
                    pend_q    <= 1'b0;
                    mem_valid <= 1'b1;
                end
            end
        end
    end

    // Outside an answer the lines carry the inverse so stale use shows.
    assign mem_resp = mem_valid ? {data, errs} : ~{data, errs};
endmodule : sal_mem_model

// file: verification/sal_datapath_tb.sv
// Self-checking bench for the scaled add and word load datapath.
module sal_datapath_tb
    import sal_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
    n_mismatch++; $display("CHECK FAILED at %0t: got %0h want %0h", \
    $time, (a), (e)); end end

    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        issue_valid = 1'b0;
    sal_issue_t  issue = '0;
    logic        release6_mode = 1'b0;
    logic        enhanced_addressing_enable_bit = 1'b1;
    logic        cop0_enabled = 1'b1;
    logic        cop1_enabled = 1'b1;
    logic        cop2_enabled = 1'b1;
    logic        cop2_present = 1'b1;
    logic        big_endian_flag = 1'b0;
    logic        reverse_endian_flag = 1'b0;
    sal_seg_t    segment_mode = SAL_SEG_UNMAPPED_USER;
    logic [3:0]  lat = 4'h1;
    logic [63:0] data = 64'h1234_5678_8765_4321;
    logic [3:0]  errs = 4'h0;
    logic        mem_valid;
    sal_mem_t    mem_resp;
    logic        busy_q;
    logic        mem_req_q;
    logic [63:0] mem_vaddr_q;
    logic        mem_user_map_q;
    logic        mem_reverse_q;
    logic        result_valid_q;
    sal_result_t result_q;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          cyc = 0;

    sal_datapath u_dut (
        .core_clk, .sys_rst, .issue_valid, .issue, .release6_mode,
        .enhanced_addressing_enable_bit, .cop0_enabled, .cop1_enabled,
        .cop2_enabled, .cop2_present, .big_endian_flag,
        .reverse_endian_flag, .segment_mode, .mem_valid, .mem_resp,
        .busy_q, .mem_req_q, .mem_vaddr_q, .mem_user_map_q,
        .mem_reverse_q, .result_valid_q, .result_q
    );
    sal_mem_model u_mem (
        .core_clk, .sys_rst, .mem_req_q, .lat, .data, .errs, .mem_valid,
        .mem_resp
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock and a cycle ceiling well above the cycles needed.
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Issue one op for a cycle, then wait a bounded time for its result.
    task automatic go(sal_op_t op, logic [5:0] mj, logic [5:0] mn,
                      logic [63:0] a, logic [15:0] off, logic [1:0] shf);
        sal_issue_t n;
        n = '0;
        n.op = op;
        n.major = mj;
        n.minor = mn;
        n.shift_amount_field = shf;
        n.scaled_source_register = a;
        n.target_register = 64'h3;
        n.base = a;
        n.offset = off;
        n.dest = 5'h03;
        @(negedge core_clk);
        issue_valid = 1'b1;
        issue = n;
        @(negedge core_clk);
        issue_valid = 1'b0;
        for (int k = 0; k < 20 && result_valid_q !== 1'b1; k++)
            @(negedge core_clk);
        `CHK(result_valid_q, 1'b1)
    endtask : go

    // Loads and the upper immediate use no scaled add codes.
    task automatic ldx(sal_op_t op, logic [63:0] a, logic [15:0] off);
        go(op, 6'h00, 6'h00, a, off, 2'b00);
    endtask : ldx

    task automatic t_scaled;
        logic [63:0] a;
        logic [63:0] s;
        a = 64'h0000_0001_4000_0001;
        for (int i = 0; i < 4; i++) begin
            s = (a << (i + 1)) + 64'h3;
            go(SAL_OP_NONE, POOL_A_MAJOR, MINOR_SCALED_WORD, a, 16'h0000,
               i[1:0]);
            `CHK(result_q.value, {{32{s[31]}}, s[31:0]})
            `CHK(result_q.exc, 7'h00)
            go(SAL_OP_NONE, POOL_S_MAJOR, MINOR_SCALED_DWORD, a, 16'h0000,
               i[1:0]);
            `CHK(result_q.value, s)
        end
        ldx(SAL_OP_UPPER_IMM, 64'h0, 16'h8001);
        `CHK(result_q.value, 64'hFFFF_FFFF_8001_0000)
        ldx(SAL_OP_UPPER_IMM, 64'h0, 16'h7FFF);
        `CHK(result_q.value, 64'h0000_0000_7FFF_0000)
    endtask : t_scaled

    // Lane choice, sign extension, slow answers and a refill fault.
    task automatic t_load;
        logic [31:0] w;
        for (int i = 0; i < 3; i++) begin
            big_endian_flag = i[0];
            reverse_endian_flag = i[0];
            lat = 4'(i + 1);
            errs = (i == 2) ? 4'h8 : 4'h0;
            w = i[0] ? data[31:0] : data[63:32];
            ldx(SAL_OP_LOAD_GENERAL, 64'h1000, 16'hFFFC);
            `CHK(mem_vaddr_q, 64'h0000_0000_0000_0FFC)
            `CHK(mem_reverse_q, i[0])
            `CHK(result_q.exc.tlb_refill, i == 2)
            if (i < 2) `CHK(result_q.value, {{32{w[31]}}, w})
            `CHK(result_q.dest, 5'h03)
        end
        ldx(SAL_OP_LOAD_GENERAL, 64'h1002, 16'h0000);
        `CHK(result_q.exc.address_error, 1'b1)
    endtask : t_load

    task automatic t_copro;
        errs = 4'h0;
        big_endian_flag = 1'b0;
        reverse_endian_flag = 1'b0;
        cop1_enabled = 1'b0;
        ldx(SAL_OP_LOAD_FLOAT, 64'h1000, 16'h0000);
        `CHK(result_q.exc.cop_unusable, 1'b1)
        cop1_enabled = 1'b1;
        ldx(SAL_OP_LOAD_FLOAT, 64'h1000, 16'h0000);
        `CHK(result_q.dst, SAL_DST_FLOAT)
        `CHK(result_q.value, 64'h0000_0000_8765_4321)
        cop2_present = 1'b0;
        ldx(SAL_OP_LOAD_COP2, 64'h2000, 16'h0400);
        `CHK(result_q.exc.reserved_instr, 1'b1)
        cop2_present = 1'b1;
        release6_mode = 1'b1;
        ldx(SAL_OP_LOAD_COP2, 64'h2000, 16'h0400);
        `CHK(mem_vaddr_q, 64'h0000_0000_0000_1C00)
        `CHK(result_q.dst, SAL_DST_COP2)
        release6_mode = 1'b0;
        ldx(SAL_OP_LOAD_COP2, 64'h2000, 16'h0400);
        `CHK(mem_vaddr_q, 64'h0000_0000_0000_2400)
        `CHK(result_q.value[31:0], 32'h8765_4321)
    endtask : t_copro

    task automatic t_user;
        enhanced_addressing_enable_bit = 1'b0;
        ldx(SAL_OP_LOAD_USER, 64'h3000, 16'h01FC);
        `CHK(result_q.exc.reserved_instr, 1'b1)
        enhanced_addressing_enable_bit = 1'b1;
        cop0_enabled = 1'b0;
        ldx(SAL_OP_LOAD_USER, 64'h3000, 16'h01FC);
        `CHK(result_q.exc.cop_unusable, 1'b1)
        cop0_enabled = 1'b1;
        segment_mode = SAL_SEG_OTHER;
        ldx(SAL_OP_LOAD_USER, 64'h3000, 16'h01FC);
        `CHK(result_q.exc.address_error, 1'b1)
        segment_mode = SAL_SEG_MAPPED_USER_FROM_KERNEL;
        ldx(SAL_OP_LOAD_USER, 64'h3000, 16'h01FC);
        `CHK(mem_vaddr_q, 64'h0000_0000_0000_2FFC)
        `CHK(mem_user_map_q, 1'b1)
        `CHK(result_q.value, 64'h0000_0000_1234_5678)
        segment_mode = SAL_SEG_MAPPED_USER;
        ldx(SAL_OP_LOAD_USER, 64'h3000, 16'h01FC);
        `CHK(result_q.exc, 7'h00)
        `CHK(mem_user_map_q, 1'b0)
    endtask : t_user

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    // Hold reset for six cycles, then run every scenario in turn.
    initial begin
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        sys_rst = 1'b0;
        t_scaled();
        $display("scaled add test done");
        t_load();
        $display("general load test done");
        t_copro();
        $display("coprocessor load test done");
        t_user();
        $display("user space load test done");
        wrap_up();
    end
endmodule : sal_datapath_tb
